// ===== rtl/flash_pin_regs.svh
// Function
// R1: chip select high tri-states every data lane
// R2: no instruction before first select falling edge
// R3: single lane samples input on clock rise
// R4: single lane output changes on clock fall
// R5: wide lanes bidirectional, rise in, fall out
// R6: four-lane transfers need four-lane enable bit
// R7: enable bit turns guard/pause pins into lanes
// R8: single and dual use lanes zero/one only
// R9: low write-guard with lock blocks status writes
// R10: pages of 256 bytes, program wraps page
// R11: erase sector, 32K, 64K block or array
// R12: 24-bit addresses, continuous read skips instruction
// R13: reads optionally wrap in 8..64 byte window
// R14: readable 64-bit unique serial number
// R15: four 256-byte security registers, each locked
// R16: idle clock level at select gives mode
// R17: pause low while selected tri-states, ignores inputs
// R18: select rising ends transfer, resets shift logic
`ifndef FLASH_PIN_REGS_SVH
`define FLASH_PIN_REGS_SVH
`define ADDR_BITS 24
`define PAGE_COUNT 16384
`define PAGE_BYTES 256
`define SECTOR_SHIFT 12
`define BLK32_SHIFT 15
`define BLK64_SHIFT 16
`define WRAP8_SHIFT 3
`define BYTE_BITS 8
`define SEC_REGS 4
`define UNIQUE_ID_RESET 64'h0123_4567_89AB_CDEF
`endif

// ===== rtl/flash_pin_pkg.sv
package flash_pin_pkg;
  // lane width asked for by the command decoder
  typedef enum logic [1:0] {
    lane_single = 2'h0,
    lane_dual = 2'h1,
    lane_quad = 2'h2
  } lane_mode_type;
  // erase granularity
  typedef enum logic [1:0] {
    erase_sector = 2'h0,
    erase_blk32 = 2'h1,
    erase_blk64 = 2'h2,
    erase_array = 2'h3
  } erase_kind_type;
  // link state, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_active = 3'b010,
    st_pause = 3'b100
  } link_state_type;
endpackage : flash_pin_pkg

// ===== rtl/page_buffer.sv
`timescale 1ns/10ps
// byte-wide buffer, registered read data
module page_buffer #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic i_clk, // system clock
  input wire logic i_we, // write strobe
  input wire logic [AW-1:0] i_waddr, // write address
  input wire logic [7:0] i_wdata, // write data
  input wire logic [AW-1:0] i_raddr, // read address
  output logic [7:0] o_rdata // registered read data
);
  logic [7:0] mem [DEPTH]; // storage
  initial begin
    if (DEPTH != (1 << AW))
    begin
      $error("page_buffer depth must be two to the address width");
    end
  end
  // write and registered read
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : page_buffer

// ===== rtl/serial_flash_pin_interface.sv
`timescale 1ns/10ps
`include "flash_pin_regs.svh"
module serial_flash_pin_interface #(
  parameter logic [63:0] UNIQUE_ID = `UNIQUE_ID_RESET // arbitrary value
) (
  input wire logic i_clk, // system clock
  input wire logic i_srst, // sync reset, high
  input wire logic i_cs_n, // chip select pin, low active
  input wire logic i_sclk, // serial clock pin
  input wire logic i_lane_zero, // lane 0 pin level (serial_in)
  input wire logic i_lane_one, // lane 1 pin level
  input wire logic i_lane_two, // lane 2 pin level / write guard, low active
  input wire logic i_lane_three, // lane 3 pin level / pause, low active
  input wire flash_pin_pkg::lane_mode_type i_lane_mode, // width of this phase
  input wire logic i_drive_out, // decoder asks to drive read data
  input wire logic [7:0] i_tx_byte, // next byte to shift out
  input wire logic i_four_lane_enable, // non-volatile enable bit
  input wire logic i_status_lock_bits, // status lock bit
  input wire logic [2:0] i_region_guard_bits, // region guard bits
  input wire logic i_page_load, // load page offset
  input wire logic [7:0] i_page_start, // page offset to load
  input wire logic i_page_fill, // received bytes go to page buffer
  input wire logic [7:0] i_buf_raddr, // page buffer read address
  input wire logic i_addr_load, // load read address
  input wire logic [`ADDR_BITS-1:0] i_addr, // read address to load
  input wire logic i_wrap_en, // wrap reads in window
  input wire logic [1:0] i_wrap_sel, // 0..3 = 8/16/32/64 bytes
  input wire flash_pin_pkg::erase_kind_type i_erase_kind, // erase size
  input wire logic [`SEC_REGS-1:0] i_sec_locks, // security lock bits
  input wire logic [1:0] i_sec_index, // security register picked
  output logic o_lane_zero, // lane 0 drive value
  output logic o_lane_zero_oe, // lane 0 drive enable
  output logic o_lane_one, // lane 1 drive value
  output logic o_lane_one_oe, // lane 1 drive enable
  output logic o_lane_two, // lane 2 drive value
  output logic o_lane_two_oe, // lane 2 drive enable
  output logic o_lane_three, // lane 3 drive value
  output logic o_lane_three_oe, // lane 3 drive enable
  output logic [7:0] o_rx_byte, // received byte
  output logic o_rx_valid, // byte pulse
  output logic o_rx_first, // byte is the instruction byte
  output logic o_tx_take, // tx byte taken pulse
  output logic o_selected, // frame in progress and not paused
  output logic o_mode3, // clock idled high at select
  output logic o_quad_refused, // quad asked without enable
  output logic o_status_write_ok, // status register may be written
  output logic o_region_guarded, // some region guard bit set
  output logic [7:0] o_page_ptr, // page fill offset
  output logic [7:0] o_buf_rdata, // page buffer data
  output logic [`ADDR_BITS-1:0] o_read_addr, // read address
  output logic [`ADDR_BITS-1:0] o_erase_base, // aligned erase base
  output logic o_sec_write_ok, // picked security register unlocked
  output logic [63:0] o_unique_id // serial number
);
  import flash_pin_pkg::*;

  initial begin
    if (`PAGE_COUNT * `PAGE_BYTES > (1 << `ADDR_BITS) || UNIQUE_ID == 64'h0)
    begin
      $error("geometry or identity value not servable");
    end
  end

  // align an address down to a power of two
  function automatic logic [`ADDR_BITS-1:0] align_down(input logic [`ADDR_BITS-1:0] a,
                                                       input int sh);
    logic [`ADDR_BITS-1:0] m;
    m = '1;
    align_down = a & (m << sh);
  endfunction : align_down

  // two-stage synchronisers plus delay for edges
  // no reset here: they always follow the pins, so a select already low
  // at reset release is not mistaken for a falling edge
  logic [4:0] sync1, sync2, sync3; // {cs_n, sclk, l3, l2, l1/l0 packed below}
  logic [1:0] low1, low2; // lane zero and one
  always_ff @(posedge i_clk)
  begin
    sync1 <= {i_cs_n, i_sclk, i_lane_three, i_lane_two, 1'b0};
    sync2 <= sync1;
    sync3 <= sync2;
    low1 <= {i_lane_one, i_lane_zero};
    low2 <= low1;
  end
  logic cs_q, sclk_q, sclk_d, cs_d, l3_q, l2_q;
  assign cs_q = sync2[4];
  assign sclk_q = sync2[3];
  assign l3_q = sync2[2];
  assign l2_q = sync2[1];
  assign cs_d = sync3[4];
  assign sclk_d = sync3[3];
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_rise = sclk_q & ~sclk_d;
  assign sclk_fall = ~sclk_q & sclk_d;
  assign cs_fall = ~cs_q & cs_d;
  assign cs_rise = cs_q & ~cs_d;

  // effective width; quad only with the enable bit
  logic quad_ok, eff_dual, eff_quad;
  // R6: quad gated
  assign quad_ok = i_four_lane_enable;
  assign eff_quad = (i_lane_mode == lane_quad) & quad_ok;
  assign eff_dual = (i_lane_mode == lane_dual);
  // R17: pause pin only without enable
  logic pause_req;
  assign pause_req = ~i_four_lane_enable & ~l3_q;

  // R2: armed only by a select falling edge
  logic armed;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      armed <= 1'b0;
    end
    else if (cs_fall)
    begin
      armed <= 1'b1;
    end
  end

  // link state; pause enters and returns to active only while clock low
  link_state_type state;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state <= st_idle;
    end
    else
    begin
      unique case (state)
        st_idle:
        begin
          if (cs_fall)
          begin
            state <= st_active;
          end
        end
        st_active:
        begin
          if (cs_q)
          begin
            state <= st_idle;
          end
          else if (pause_req & ~sclk_q)
          begin
            state <= st_pause;
          end
        end
        st_pause:
        begin
          if (cs_q)
          begin
            state <= st_idle;
          end
          else if (~pause_req & ~sclk_q)
          begin
            state <= st_active;
          end
        end
        default:
        begin
          state <= st_idle;
        end
      endcase
    end
  end
  logic live;
  assign live = (state == st_active) & ~cs_q & armed;

  // R16: idle clock level at select falling edge
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_mode3 <= 1'b0;
    end
    else if (cs_fall)
    begin
      o_mode3 <= sclk_d;
    end
  end

  // receive shifter on clock rise
  logic [7:0] rx_sh;
  logic [3:0] rx_cnt;
  logic [7:0] next_rx;
  logic [3:0] next_cnt;
  logic first_pending;
  always_comb
  begin
    // R3 R5 R8: lanes used depend on width
    if (eff_quad)
    begin
      next_rx = {rx_sh[3:0], l3_q, l2_q, low2[1], low2[0]};
      next_cnt = rx_cnt + 4'h4;
    end
    else if (eff_dual)
    begin
      next_rx = {rx_sh[5:0], low2[1], low2[0]};
      next_cnt = rx_cnt + 4'h2;
    end
    else
    begin
      next_rx = {rx_sh[6:0], low2[0]};
      next_cnt = rx_cnt + 4'h1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rx_sh <= 8'h00;
      rx_cnt <= 4'h0;
      o_rx_byte <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_first <= 1'b0;
      first_pending <= 1'b1;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      // R18: select rising resets shifting
      if (cs_q)
      begin
        rx_cnt <= 4'h0;
        first_pending <= 1'b1;
      end
      // R3: capture on rise while not driving
      else if (live & sclk_rise & ~i_drive_out)
      begin
        if (next_cnt == 4'(`BYTE_BITS))
        begin
          rx_cnt <= 4'h0;
          o_rx_byte <= next_rx;
          o_rx_valid <= 1'b1;
          o_rx_first <= first_pending;
          first_pending <= 1'b0;
        end
        else
        begin
          rx_cnt <= next_cnt;
        end
        rx_sh <= next_rx;
      end
    end
  end

  // transmit shifter and lane drivers on clock fall
  logic [7:0] tx_sh;
  logic [3:0] tx_cnt;
  logic [7:0] cur;
  assign cur = (tx_cnt == 4'h0) ? i_tx_byte : tx_sh;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      tx_sh <= 8'h00;
      tx_cnt <= 4'h0;
      o_tx_take <= 1'b0;
      {o_lane_three, o_lane_two, o_lane_one, o_lane_zero} <= 4'h0;
      {o_lane_three_oe, o_lane_two_oe, o_lane_one_oe, o_lane_zero_oe} <= 4'h0;
    end
    else
    begin
      o_tx_take <= 1'b0;
      // R1 R17: off while deselected or paused
      if (~live | ~i_drive_out)
      begin
        {o_lane_three_oe, o_lane_two_oe, o_lane_one_oe, o_lane_zero_oe} <= 4'h0;
        if (cs_q)
        begin
          tx_cnt <= 4'h0;
        end
      end
      // R4 R5: change on clock fall
      else if (sclk_fall)
      begin
        o_tx_take <= (tx_cnt == 4'h0);
        if (eff_quad)
        begin
          // R7: guard and pause pins carry data
          {o_lane_three, o_lane_two, o_lane_one, o_lane_zero} <= cur[7:4];
          {o_lane_three_oe, o_lane_two_oe, o_lane_one_oe, o_lane_zero_oe} <= 4'hF;
          tx_sh <= {cur[3:0], 4'h0};
          tx_cnt <= (tx_cnt == 4'h4) ? 4'h0 : tx_cnt + 4'h4;
        end
        else if (eff_dual)
        begin
          // R8: lanes zero and one only
          {o_lane_one, o_lane_zero} <= cur[7:6];
          {o_lane_three_oe, o_lane_two_oe, o_lane_one_oe, o_lane_zero_oe} <= 4'h3;
          tx_sh <= {cur[5:0], 2'h0};
          tx_cnt <= (tx_cnt == 4'h6) ? 4'h0 : tx_cnt + 4'h2;
        end
        else
        begin
          o_lane_one <= cur[7];
          {o_lane_three_oe, o_lane_two_oe, o_lane_one_oe, o_lane_zero_oe} <= 4'h2;
          tx_sh <= {cur[6:0], 1'b0};
          tx_cnt <= (tx_cnt == 4'h7) ? 4'h0 : tx_cnt + 4'h1;
        end
      end
    end
  end

  // status flags, guard, geometry and identity outputs
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_selected <= 1'b0;
      o_quad_refused <= 1'b0;
      o_status_write_ok <= 1'b0;
      o_region_guarded <= 1'b0;
      o_erase_base <= '0;
      o_sec_write_ok <= 1'b0;
      o_unique_id <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      o_selected <= live;
      o_quad_refused <= (i_lane_mode == lane_quad) & ~quad_ok;
      // R9: guard pin low with lock blocks writes while the enable bit is clear
      o_status_write_ok <= ~(i_status_lock_bits & ~l2_q & ~i_four_lane_enable);
      o_region_guarded <= |i_region_guard_bits;
      // R11: erase region alignment
      unique case (i_erase_kind)
        erase_sector: o_erase_base <= align_down(o_read_addr, `SECTOR_SHIFT);
        erase_blk32: o_erase_base <= align_down(o_read_addr, `BLK32_SHIFT);
        erase_blk64: o_erase_base <= align_down(o_read_addr, `BLK64_SHIFT);
        erase_array: o_erase_base <= '0;
      endcase
      // R15: per-register one-time lock
      o_sec_write_ok <= ~i_sec_locks[i_sec_index];
      // R14: serial number
      o_unique_id <= UNIQUE_ID;
    end
  end

  // R12 R13: 24-bit read address, optional window wrap
  logic [`ADDR_BITS-1:0] wmask;
  assign wmask = `ADDR_BITS'((1 << (`WRAP8_SHIFT + i_wrap_sel)) - 1);
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_read_addr <= '0;
    end
    else if (i_addr_load)
    begin
      o_read_addr <= i_addr;
    end
    else if (o_tx_take)
    begin
      if (i_wrap_en)
      begin
        o_read_addr <= (o_read_addr & ~wmask) | ((o_read_addr + 1'b1) & wmask);
      end
      else
      begin
        o_read_addr <= o_read_addr + 1'b1;
      end
    end
  end

  // R10: page fill pointer wraps inside one page
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_page_ptr <= 8'h00;
    end
    else if (i_page_load)
    begin
      o_page_ptr <= i_page_start;
    end
    else if (o_rx_valid & i_page_fill)
    begin
      o_page_ptr <= o_page_ptr + 8'h01;
    end
  end
  page_buffer #(.DEPTH(`PAGE_BYTES), .AW(8)) u_page (
    .i_clk(i_clk),
    .i_we(o_rx_valid & i_page_fill),
    .i_waddr(o_page_ptr),
    .i_wdata(o_rx_byte),
    .i_raddr(i_buf_raddr),
    .o_rdata(o_buf_rdata)
  );

  // checks
  property p_cs_hiz;
    @(posedge i_clk) disable iff (i_srst)
    cs_q |=> !(o_lane_zero_oe | o_lane_one_oe | o_lane_two_oe | o_lane_three_oe);
  endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("lane driven while deselected"); // R1
  property p_armed;
    @(posedge i_clk) disable iff (i_srst) !armed |=> !o_rx_valid;
  endproperty
  a_armed: assert property (p_armed) else $error("byte before first select"); // R2
  property p_rx_rise;
    @(posedge i_clk) disable iff (i_srst) o_rx_valid |-> $past(sclk_rise);
  endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("byte not on rise"); // R3
  property p_tx_fall;
    @(posedge i_clk) disable iff (i_srst)
    o_tx_take |-> $past(sclk_fall) && o_lane_one_oe;
  endproperty
  a_tx_fall: assert property (p_tx_fall) else $error("output not on fall"); // R4
  property p_quad;
    @(posedge i_clk) disable iff (i_srst)
    o_lane_two_oe |-> $past(i_four_lane_enable);
  endproperty
  a_quad: assert property (p_quad) else $error("quad lanes without enable"); // R6
  property p_guard;
    @(posedge i_clk) disable iff (i_srst)
    (i_status_lock_bits && !l2_q && !i_four_lane_enable) |=> !o_status_write_ok;
  endproperty
  a_guard: assert property (p_guard) else $error("status write not blocked"); // R9
  property p_page_wrap;
    @(posedge i_clk) disable iff (i_srst)
    (o_page_ptr == 8'hFF && o_rx_valid && i_page_fill && !i_page_load) |=> o_page_ptr == 8'h00;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page pointer left page"); // R10
  property p_pause;
    @(posedge i_clk) disable iff (i_srst)
    (state == st_pause) |=> !o_lane_one_oe ##1 !o_rx_valid;
  endproperty
  a_pause: assert property (p_pause) else $error("activity while paused"); // R17
  property p_cs_end;
    @(posedge i_clk) disable iff (i_srst) cs_rise |=> rx_cnt == 4'h0 && tx_cnt == 4'h0;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("shift state kept past frame"); // R18
  c_byte: cover property (@(posedge i_clk) disable iff (i_srst) o_rx_valid && o_rx_first);
  c_quad_out: cover property (@(posedge i_clk) disable iff (i_srst) o_lane_three_oe);
  c_pause: cover property (@(posedge i_clk) disable iff (i_srst) state == st_pause);
endmodule : serial_flash_pin_interface

// ===== bench/spi_host_model.sv
`timescale 1ns/10ps
// spi host: drives select, clock and lanes; clock stands still between frames
module spi_host_model (
  output logic o_cs_n, // chip select, low active
  output logic o_sclk, // serial clock
  output logic [3:0] o_lane, // lane drive values
  output logic [3:0] o_lane_oe, // lane drive enables
  input wire logic [3:0] i_lane_level // resolved lane levels
);
  // select starts low from power-up, so the first frame lacks a falling edge
  initial
  begin
    o_cs_n = 1'b0;
    o_sclk = 1'b0;
    o_lane = 4'h0;
    o_lane_oe = 4'h0;
  end
  task select(input logic mode3);
    o_sclk = mode3;
    #40 o_cs_n = 1'b0;
    #40;
  endtask : select
  // end of frame; released lanes zero and one show the inverse of the last value
  task deselect();
    #40 o_cs_n = 1'b1;
    #10 o_lane_oe = 4'h0;
    o_lane = ~o_lane;
    #40;
  endtask : deselect
  // data set up before each rise
  task send(input int w, input logic [7:0] b, input int e0, input int e1);
    logic [7:0] sh;
    for (int e = e0; e < e1; e++)
    begin
      sh = b << (e * w);
      o_lane_oe = 4'((1 << w) - 1);
      o_lane = 4'(sh[7:4] >> (4 - w));
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
  endtask : send
  // sample before each rise, device moved on the fall
  task recv(input int w, output logic [7:0] b);
    o_lane_oe = 4'h0;
    o_lane = ~o_lane;
    b = 8'h00;
    for (int e = 0; e < 8 / w; e++)
    begin
      #32 o_sclk = 1'b0;
      #32;
      if (w == 1)
        b = {b[6:0], i_lane_level[1]};
      else
        b = 8'((b << w) | (i_lane_level & 4'((1 << w) - 1)));
      o_sclk = 1'b1;
    end
  endtask : recv
endmodule : spi_host_model

// ===== bench/serial_flash_pin_interface_bench.sv
`timescale 1ns/10ps
`include "flash_pin_regs.svh"
// self-checking bench for the flash pin front end
module serial_flash_pin_interface_bench;
  import flash_pin_pkg::*;
  logic i_clk, i_srst, i_drive_out, i_four_lane_enable, i_status_lock_bits; // controls
  logic i_page_load, i_page_fill, i_addr_load, i_wrap_en; // strobes and levels
  logic [7:0] i_tx_byte, i_page_start, i_buf_raddr; // byte inputs
  logic [2:0] i_region_guard_bits; // guard bits
  logic [`ADDR_BITS-1:0] i_addr; // read address
  logic [1:0] i_wrap_sel, i_sec_index; // selectors
  logic [3:0] i_sec_locks; // security locks
  lane_mode_type i_lane_mode; // phase width
  erase_kind_type i_erase_kind; // erase size
  logic wp_lvl, hold_lvl; // guard and pause levels when nobody drives
  wire cs_n, sclk; // link pins
  wire [3:0] h_lane, h_oe, lvl, d_lane, d_oe; // host, resolved and device lanes
  wire [7:0] o_rx_byte, o_page_ptr, o_buf_rdata; // byte outputs
  wire o_rx_valid, o_rx_first, o_tx_take, o_selected, o_mode3, o_quad_refused; // flags
  wire o_status_write_ok, o_region_guarded, o_sec_write_ok; // guard outputs
  wire [`ADDR_BITS-1:0] o_read_addr, o_erase_base; // addresses
  wire [63:0] o_unique_id; // serial number
  integer seed = 32'he861cca1; // random seed
  int fails = 0, n_tests = 0, csh = 0, k, win; // counters
  logic [8:0] exp_q[$]; // expected {first, byte}
  logic [7:0] b, pb[4]; // bytes
  logic [23:0] a, ea; // addresses
  lane_mode_type cm[4] = '{lane_single, lane_dual, lane_quad, lane_quad}; // cases
  logic ce[4] = '{1'b0, 1'b0, 1'b1, 1'b0}; // enable per case
  int cw[4] = '{1, 2, 4, 1}; // effective width per case
  logic [23:0] emask[4] = '{24'hff_f000, 24'hff_8000, 24'hff_0000, 24'h00_0000};
  // wire levels: device wins, then host, then pin level on lanes two and three only
  assign lvl[0] = d_oe[0] ? d_lane[0] : h_lane[0];
  assign lvl[1] = d_oe[1] ? d_lane[1] : h_lane[1];
  assign lvl[2] = d_oe[2] ? d_lane[2] : h_oe[2] ? h_lane[2] : wp_lvl;
  assign lvl[3] = d_oe[3] ? d_lane[3] : h_oe[3] ? h_lane[3] : hold_lvl;
  spi_host_model i_spi_host_model (.o_cs_n(cs_n), .o_sclk(sclk), .o_lane(h_lane),
    .o_lane_oe(h_oe), .i_lane_level(lvl));
  serial_flash_pin_interface i_serial_flash_pin_interface (.i_clk(i_clk), .i_srst(i_srst),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_lane_zero(lvl[0]), .i_lane_one(lvl[1]),
    .i_lane_two(lvl[2]), .i_lane_three(lvl[3]), .i_lane_mode(i_lane_mode),
    .i_drive_out(i_drive_out), .i_tx_byte(i_tx_byte), .i_four_lane_enable(i_four_lane_enable),
    .i_status_lock_bits(i_status_lock_bits), .i_region_guard_bits(i_region_guard_bits),
    .i_page_load(i_page_load), .i_page_start(i_page_start), .i_page_fill(i_page_fill),
    .i_buf_raddr(i_buf_raddr), .i_addr_load(i_addr_load), .i_addr(i_addr),
    .i_wrap_en(i_wrap_en), .i_wrap_sel(i_wrap_sel), .i_erase_kind(i_erase_kind),
    .i_sec_locks(i_sec_locks), .i_sec_index(i_sec_index), .o_lane_zero(d_lane[0]),
    .o_lane_zero_oe(d_oe[0]), .o_lane_one(d_lane[1]), .o_lane_one_oe(d_oe[1]),
    .o_lane_two(d_lane[2]), .o_lane_two_oe(d_oe[2]), .o_lane_three(d_lane[3]),
    .o_lane_three_oe(d_oe[3]), .o_rx_byte(o_rx_byte), .o_rx_valid(o_rx_valid),
    .o_rx_first(o_rx_first), .o_tx_take(o_tx_take), .o_selected(o_selected),
    .o_mode3(o_mode3), .o_quad_refused(o_quad_refused), .o_status_write_ok(o_status_write_ok),
    .o_region_guarded(o_region_guarded), .o_page_ptr(o_page_ptr), .o_buf_rdata(o_buf_rdata),
    .o_read_addr(o_read_addr), .o_erase_base(o_erase_base), .o_sec_write_ok(o_sec_write_ok),
    .o_unique_id(o_unique_id));
  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // compare and count
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // wait edges, then step just past the edge
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // verdict and end of run
  task summarize();
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // byte model and deselect watch
  always @(posedge i_clk)
  begin
    csh <= cs_n ? csh + 1 : 0;
    if (csh > 6)
      chk(d_oe, 4'h0, "lane driven while deselected");
    if (!i_srst && o_rx_valid)
    begin
      if (exp_q.size() == 0)
        chk(1'b1, 1'b0, "unexpected byte");
      else
        chk({o_rx_first, o_rx_byte}, exp_q.pop_front(), "rx byte");
    end
  end
  // watchdog
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
  // main sequence
  initial
  begin
    {i_srst, i_drive_out, i_four_lane_enable, i_status_lock_bits, i_page_load} = 5'h10;
    {i_page_fill, i_addr_load, i_wrap_en, wp_lvl, hold_lvl} = 5'h03;
    {i_tx_byte, i_page_start, i_buf_raddr, i_region_guard_bits} = 27'h0;
    {i_addr, i_wrap_sel, i_sec_index, i_sec_locks} = 32'h0;
    i_lane_mode = lane_single;
    i_erase_kind = erase_sector;
    tick(6);
    i_srst = 1'b0;
    tick(2);
    i_spi_host_model.send(1, 8'($random(seed)), 0, 8);
    i_spi_host_model.deselect();
    i_spi_host_model.select(1'b0);
    tick(1);
    chk(o_mode3, 1'b0, "mode 0");
    i_page_start = 8'hfe;
    i_page_load = 1'b1;
    tick(1);
    i_page_load = 1'b0;
    i_page_fill = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      i_lane_mode = cm[k];
      i_four_lane_enable = ce[k];
      b = 8'($random(seed));
      pb[k] = b;
      tick(2);
      chk(o_quad_refused, cm[k] == lane_quad && !ce[k], "quad refusal");
      exp_q.push_back({k == 0, b});
      i_spi_host_model.send(cw[k], b, 0, 8 / cw[k]);
      tick(8);
    end
    i_page_fill = 1'b0;
    chk(o_page_ptr, 8'h02, "page pointer wrap");
    for (k = 0; k < 4; k++)
    begin
      i_buf_raddr = 8'(8'hfe + k);
      tick(2);
      chk(o_buf_rdata, pb[k], "page data");
    end
    i_lane_mode = lane_single;
    i_four_lane_enable = 1'b0;
    i_spi_host_model.send(1, 8'hff, 0, 5);
    i_spi_host_model.deselect();
    i_spi_host_model.select(1'b0);
    b = 8'($random(seed));
    exp_q.push_back({1'b1, b});
    i_spi_host_model.send(1, b, 0, 4);
    tick(1);
    hold_lvl = 1'b0;
    tick(6);
    chk(o_selected, 1'b0, "paused frame");
    i_spi_host_model.send(1, ~b, 0, 8);
    tick(1);
    hold_lvl = 1'b1;
    tick(6);
    i_spi_host_model.send(1, b, 4, 8);
    tick(8);
    i_spi_host_model.deselect();
    tick(1);
    chk(exp_q.size(), 0, "bytes missing");
    a = 24'($random(seed));
    i_addr = a;
    i_wrap_sel = 2'($random(seed));
    i_wrap_en = 1'b1;
    i_addr_load = 1'b1;
    tick(1);
    i_addr_load = 1'b0;
    for (k = 0; k < 4; k++)
    begin
      i_lane_mode = cm[k];
      i_four_lane_enable = ce[k];
      i_tx_byte = 8'($random(seed));
      i_drive_out = 1'b1;
      i_spi_host_model.select(1'b1);
      chk(o_mode3, 1'b1, "mode 3");
      fork
        i_spi_host_model.recv(cw[k], b);
        #300 chk(d_oe, {{2{cw[k] == 4}}, 1'b1, cw[k] > 1}, "lane enables");
      join
      chk(b, i_tx_byte, "read byte");
      tick(1);
      i_drive_out = 1'b0;
      i_spi_host_model.deselect();
      tick(1);
    end
    win = 8 << i_wrap_sel;
    ea = (a & ~24'(win - 1)) | ((a + 24'h00_0004) & 24'(win - 1));
    chk(o_read_addr, ea, "wrapped address");
    for (k = 0; k < 4; k++)
    begin
      i_erase_kind = erase_kind_type'(k);
      tick(3);
      chk(o_erase_base, ea & emask[k], "erase base");
    end
    for (k = 0; k < 8; k++)
    begin
      {i_status_lock_bits, wp_lvl, i_four_lane_enable} = 3'(k);
      i_region_guard_bits = 3'($random(seed));
      tick(6);
      chk(o_status_write_ok, !(k[2] && !k[1] && !k[0]), "status guard");
      chk(o_region_guarded, |i_region_guard_bits, "region guard");
    end
    i_sec_locks = 4'($random(seed));
    for (k = 0; k < 4; k++)
    begin
      i_sec_index = 2'(k);
      tick(3);
      chk(o_sec_write_ok, !i_sec_locks[k], "security lock");
    end
    chk(o_unique_id, `UNIQUE_ID_RESET, "unique id");
    summarize();
  end
endmodule : serial_flash_pin_interface_bench
